// ===== src/ifs_consts.svh
`ifndef IFS_CONSTS_SVH
`define IFS_CONSTS_SVH

// register offsets (word addresses on the plain register port)
`define IFS_ADDR_W 4
`define IFS_OFS_WORD_ONE 4'h0
`define IFS_OFS_WORD_TWO 4'h1
`define IFS_OFS_WORD_THREE 4'h2
`define IFS_OFS_PENDING 4'h3

// field positions, word one
`define IFS_BIT_TW1_MASTER 1
// field positions, word two
`define IFS_BIT_CAP3 5
`define IFS_BIT_SP2_EVENT 1
`define IFS_BIT_SP2_FAULT 0
// field positions, word three
`define IFS_BIT_CAL_CLOCK 14
`define IFS_BIT_TW2_MASTER 2
`define IFS_BIT_TW2_SLAVE 1

// implemented-bit masks and reset values
`define IFS_MASK_WORD_ONE 16'h0002
`define IFS_MASK_WORD_TWO 16'h0023
`define IFS_MASK_WORD_THREE 16'h4006
`define IFS_RESET_WORD 16'h0000
`define IFS_RESET_FLAG 1'h0

`endif

// ===== src/ifs_pkg.sv
package ifs_pkg;

    // hardware request pulses or levels from the peripherals
    typedef struct packed {
        logic twowire_one_master;
        logic capture_three;
        logic serial_port_two_event;
        logic serial_port_two_fault;
        logic calendar_clock;
        logic twowire_two_master;
        logic twowire_two_slave;
    } ifs_src_t;

    typedef struct packed {
        logic [15:0] word_one;
        logic [15:0] word_two;
        logic [15:0] word_three;
    } ifs_flags_t;

endpackage : ifs_pkg

// ===== src/ifs_flag_regs.sv
// Contract
// - Unimplemented bits read zero; word two bits 15-6 and 4-2.
// - Word three bits 15, 13-3 and 0 read zero, writes ignored.
// - Hardware sets a flag on request regardless of a same-cycle write.
// - A flag reads one after a request or a write of one, until a write of zero clears it.
// - Word two bit 5 latches input capture channel three requests.
// - Word two bit 1 latches second serial port event requests.
// - Word two bit 0 latches second serial port fault requests.
// - Word three bit 14 latches calendar clock requests.
// - Word three bit 2 latches second two-wire master events.
// - Word three bit 1 latches second two-wire slave events.
// - Word one bit 1 latches first two-wire master events.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`include "ifs_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module ifs_flag_regs (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire ifs_pkg::ifs_src_t i_src,
    input wire logic [`IFS_ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    output ifs_pkg::ifs_flags_t o_pending,
    output logic o_any_pending
);

    // one register per implemented flag; unimplemented bits hold no state at all
    logic tw1_master_q;
    logic tw1_master_d;
    logic cap3_q;
    logic cap3_d;
    logic sp2_event_q;
    logic sp2_event_d;
    logic sp2_fault_q;
    logic sp2_fault_d;
    logic cal_clock_q;
    logic cal_clock_d;
    logic tw2_master_q;
    logic tw2_master_d;
    logic tw2_slave_q;
    logic tw2_slave_d;
    logic hit_word_one;
    logic hit_word_two;
    logic hit_word_three;
    ifs_pkg::ifs_flags_t flags;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;

    function automatic logic ifs_hit(
        input logic wr,
        input logic [`IFS_ADDR_W-1:0] addr,
        input logic [`IFS_ADDR_W-1:0] ofs
    );
        ifs_hit = wr && (addr == ofs);
    endfunction : ifs_hit

    // write first, then the request on top: a set in the clearing cycle is not lost
    function automatic logic ifs_flag_next(
        input logic cur,
        input logic set,
        input logic hit,
        input logic wbit
    );
        logic v;
        v = hit ? wbit : cur;
        ifs_flag_next = v | set;
    endfunction : ifs_flag_next

    function automatic logic [15:0] ifs_word_one(
        input logic tw1_master
    );
        logic [15:0] w;
        w = 16'h0000;
        w[`IFS_BIT_TW1_MASTER] = tw1_master;
        ifs_word_one = w & `IFS_MASK_WORD_ONE;
    endfunction : ifs_word_one

    function automatic logic [15:0] ifs_word_two(
        input logic cap3,
        input logic sp2_event,
        input logic sp2_fault
    );
        logic [15:0] w;
        w = 16'h0000;
        w[`IFS_BIT_CAP3] = cap3;
        w[`IFS_BIT_SP2_EVENT] = sp2_event;
        w[`IFS_BIT_SP2_FAULT] = sp2_fault;
        ifs_word_two = w & `IFS_MASK_WORD_TWO;
    endfunction : ifs_word_two

    function automatic logic [15:0] ifs_word_three(
        input logic cal_clock,
        input logic tw2_master,
        input logic tw2_slave
    );
        logic [15:0] w;
        w = 16'h0000;
        w[`IFS_BIT_CAL_CLOCK] = cal_clock;
        w[`IFS_BIT_TW2_MASTER] = tw2_master;
        w[`IFS_BIT_TW2_SLAVE] = tw2_slave;
        ifs_word_three = w & `IFS_MASK_WORD_THREE;
    endfunction : ifs_word_three

    // unmapped addresses read zero
    function automatic logic [15:0] ifs_read(
        input logic [`IFS_ADDR_W-1:0] addr,
        input ifs_pkg::ifs_flags_t f,
        input logic any
    );
        logic [15:0] r;
        r = 16'h0000;
        unique case (addr)
            `IFS_OFS_WORD_ONE: r = f.word_one;
            `IFS_OFS_WORD_TWO: r = f.word_two;
            `IFS_OFS_WORD_THREE: r = f.word_three;
            `IFS_OFS_PENDING: r = {15'h0000, any};
            default: r = 16'h0000;
        endcase
        ifs_read = r;
    endfunction : ifs_read

    always_comb begin
        hit_word_one = ifs_hit(i_wr, i_addr, `IFS_OFS_WORD_ONE);
        hit_word_two = ifs_hit(i_wr, i_addr, `IFS_OFS_WORD_TWO);
        hit_word_three = ifs_hit(i_wr, i_addr, `IFS_OFS_WORD_THREE);
    end

    // sources are on this clock, so no synchroniser
    always_comb begin
        tw1_master_d = ifs_flag_next(
            tw1_master_q,
            i_src.twowire_one_master,
            hit_word_one,
            i_wdata[`IFS_BIT_TW1_MASTER]
        );
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tw1_master_q <= `IFS_RESET_FLAG;
        end else begin
            tw1_master_q <= tw1_master_d;
        end
    end

    always_comb begin
        cap3_d = ifs_flag_next(
            cap3_q,
            i_src.capture_three,
            hit_word_two,
            i_wdata[`IFS_BIT_CAP3]
        );
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cap3_q <= `IFS_RESET_FLAG;
        end else begin
            cap3_q <= cap3_d;
        end
    end

    always_comb begin
        sp2_event_d = ifs_flag_next(
            sp2_event_q,
            i_src.serial_port_two_event,
            hit_word_two,
            i_wdata[`IFS_BIT_SP2_EVENT]
        );
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sp2_event_q <= `IFS_RESET_FLAG;
        end else begin
            sp2_event_q <= sp2_event_d;
        end
    end

    always_comb begin
        sp2_fault_d = ifs_flag_next(
            sp2_fault_q,
            i_src.serial_port_two_fault,
            hit_word_two,
            i_wdata[`IFS_BIT_SP2_FAULT]
        );
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sp2_fault_q <= `IFS_RESET_FLAG;
        end else begin
            sp2_fault_q <= sp2_fault_d;
        end
    end

    always_comb begin
        cal_clock_d = ifs_flag_next(
            cal_clock_q,
            i_src.calendar_clock,
            hit_word_three,
            i_wdata[`IFS_BIT_CAL_CLOCK]
        );
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cal_clock_q <= `IFS_RESET_FLAG;
        end else begin
            cal_clock_q <= cal_clock_d;
        end
    end

    always_comb begin
        tw2_master_d = ifs_flag_next(
            tw2_master_q,
            i_src.twowire_two_master,
            hit_word_three,
            i_wdata[`IFS_BIT_TW2_MASTER]
        );
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tw2_master_q <= `IFS_RESET_FLAG;
        end else begin
            tw2_master_q <= tw2_master_d;
        end
    end

    always_comb begin
        tw2_slave_d = ifs_flag_next(
            tw2_slave_q,
            i_src.twowire_two_slave,
            hit_word_three,
            i_wdata[`IFS_BIT_TW2_SLAVE]
        );
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tw2_slave_q <= `IFS_RESET_FLAG;
        end else begin
            tw2_slave_q <= tw2_slave_d;
        end
    end

    always_comb begin
        flags.word_one = ifs_word_one(tw1_master_q);
        flags.word_two = ifs_word_two(cap3_q, sp2_event_q, sp2_fault_q);
        flags.word_three = ifs_word_three(cal_clock_q, tw2_master_q, tw2_slave_q);
    end

    // read data valid only in the cycle after the read strobe, zero otherwise
    always_comb begin
        rdata_d = 16'h0000;
        if (i_rd) begin
            rdata_d = ifs_read(i_addr, flags, o_any_pending);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_q <= `IFS_RESET_WORD;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_pending = flags;
    assign o_any_pending = |flags;

endmodule : ifs_flag_regs

`default_nettype wire

// ===== bench/ifs_flag_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none
module ifs_flag_regs_checker (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire ifs_pkg::ifs_src_t i_src,
    input wire ifs_pkg::ifs_flags_t o_pending
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    dead_bits_a: assert property (!(o_pending & ~48'h000200234006)) else $error("bit");
    cap_set_a: assert property (i_src[5] |=> o_pending.word_two[5]) else $error("set");
    spe_set_a: assert property (i_src[4] |=> o_pending.word_two[1]) else $error("set");
    spf_set_a: assert property (i_src[3] |=> o_pending.word_two[0]) else $error("set");
    cal_set_a: assert property (i_src[2] |=> o_pending.word_three[14]) else $error("set");
    tm2_set_a: assert property (i_src[1] |=> o_pending.word_three[2]) else $error("set");
    ts2_set_a: assert property (i_src[0] |=> o_pending.word_three[1]) else $error("set");
    tm1_set_a: assert property (i_src[6] |=> o_pending.word_one[1]) else $error("set");
endmodule : ifs_flag_regs_checker
bind ifs_flag_regs ifs_flag_regs_checker chk (.*);
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n,e,s) begin n_tests++; if ((s)!==(e)) begin mismatches++; $display("BAD %s exp %h got %h",n,e,s); end end
module tb;
    logic i_ref_clk = 1'h0, i_resetn = 1'h0, i_wr = 1'h0, i_rd = 1'h0, o_any_pending;
    ifs_pkg::ifs_src_t i_src = '0;
    ifs_pkg::ifs_flags_t o_pending;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000, o_rdata;
    int mismatches = 0, n_tests = 0, cyc = 0;
    logic [26:0] rows [7] = '{27'h4000002, 27'h2010020, 27'h1010002, 27'h0810001,
        27'h0424000, 27'h0220004, 27'h0120002};
    ifs_flag_regs uut (.*);
    always #4 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) if (++cyc > 1000) report_and_stop(1);
    task automatic report_and_stop(input int to);
        mismatches += to;
        $display("%0d bad of %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        {i_wr, i_rd} <= {w, !w};
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        {i_wr, i_rd} <= 2'h0;
        #1 if (!w) `CHK("rdata", d, o_rdata)
    endtask : bus
    initial begin
        repeat (16) @(posedge i_ref_clk);
        i_resetn <= 1'h1;
        bus(1'h0, 4'h3, 16'h0000);
        foreach (rows[k]) begin
            i_src <= rows[k][26:20];
            bus(1'h0, rows[k][19:16], rows[k][15:0]);
            `CHK("any_pending", 1'h1, o_any_pending)
            i_src <= '0;
            bus(1'h1, rows[k][19:16], 16'h0000);
            bus(1'h0, rows[k][19:16], 16'h0000);
            `CHK("any_pending", 1'h0, o_any_pending)
        end
        for (int a = 0; a < 3; a++) bus(1'h1, a[3:0], 16'hFFFF);
        `CHK("pending", 48'h000200234006, o_pending)
        bus(1'h0, 4'h0, 16'h0002);
        bus(1'h0, 4'h1, 16'h0023);
        bus(1'h0, 4'h2, 16'h4006);
        bus(1'h0, 4'h3, 16'h0001);
        bus(1'h0, 4'hF, 16'h0000);
        i_src <= 7'h04;
        bus(1'h1, 4'h2, 16'h0000);
        bus(1'h0, 4'h2, 16'h4000);
        `CHK("pending", 48'h000200234000, o_pending)
        i_src <= '0;
        i_resetn <= 1'h0;
        @(posedge i_ref_clk);
        #1 `CHK("pending", 48'h000000000000, o_pending)
        `CHK("rdata", 16'h0000, o_rdata)
        i_resetn <= 1'h1;
        bus(1'h0, 4'h1, 16'h0000);
        report_and_stop(0);
    end
endmodule : tb
`default_nettype wire
